// ===== pkg/twdr_defs.svh
`ifndef TWDR_DEFS_SVH
`define TWDR_DEFS_SVH

////////////////////////////////////////////////////////////////////////////////
// Data register addresses reached through the select register
`define TWDR_ADDR_PART_ID      8'h00
`define TWDR_ADDR_REVISION     8'h01
`define TWDR_ADDR_FLASH_CTRL   8'h02
`define TWDR_ADDR_FLASH_DATA   8'hbf
`define TWDR_ADDR_CSUM_AUTO    8'h96
`define TWDR_ADDR_CSUM_COUNT   8'h97
`define TWDR_ADDR_CSUM_CTRL    8'h91
`define TWDR_ADDR_CSUM_RESULT  8'hd9
`define TWDR_ADDR_CSUM_REVERSE 8'h95
`define TWDR_ADDR_CSUM_INPUT   8'h94

////////////////////////////////////////////////////////////////////////////////
// Reset values and refused-access read data
`define TWDR_SELECT_RESET      8'h00
`define TWDR_CTRL_RESET        8'h00
`define TWDR_REFUSED_DATA      8'h00

////////////////////////////////////////////////////////////////////////////////
// Flash unlock sequence and flash command codes
`define TWDR_UNLOCK_FIRST      8'h02
`define TWDR_UNLOCK_SECOND     8'h01
`define TWDR_FCMD_BLOCK_READ   8'h06
`define TWDR_FCMD_BLOCK_WRITE  8'h07
`define TWDR_FCMD_PAGE_ERASE   8'h08
`define TWDR_FCMD_DEVICE_ERASE 8'h03

////////////////////////////////////////////////////////////////////////////////
// Link frame instruction codes and last bit index
`define TWDR_INS_DATA_READ     2'h0
`define TWDR_INS_DATA_WRITE    2'h1
`define TWDR_INS_ADDR_READ     2'h2
`define TWDR_INS_ADDR_WRITE    2'h3
`define TWDR_LAST_BIT          3'h7

`endif

// ===== pkg/twdr_pkg.sv
`include "twdr_defs.svh"

package twdr_pkg;

    // Link side frame states
    typedef enum logic [2:0] {
        LK_IDLE,
        LK_INS,
        LK_WDATA,
        LK_WAIT,
        LK_RDY,
        LK_RDATA
    } twdr_link_state_t;

    // System side access states
    typedef enum logic [0:0] {
        SY_IDLE,
        SY_CORE
    } twdr_sys_state_t;

    // Flash unlock progress
    typedef enum logic [1:0] {
        UL_LOCKED,
        UL_HALF,
        UL_OPEN
    } twdr_unlock_state_t;

    // Checksum unit register decode
    function automatic logic twdr_is_checksum(input logic [7:0] addr);
        twdr_is_checksum = (addr == `TWDR_ADDR_CSUM_AUTO)
                        || (addr == `TWDR_ADDR_CSUM_COUNT)
                        || (addr == `TWDR_ADDR_CSUM_CTRL)
                        || (addr == `TWDR_ADDR_CSUM_RESULT)
                        || (addr == `TWDR_ADDR_CSUM_REVERSE)
                        || (addr == `TWDR_ADDR_CSUM_INPUT);
    endfunction : twdr_is_checksum

    // Identification registers answered on the link side
    function automatic logic twdr_is_local(input logic [7:0] addr);
        twdr_is_local = (addr == `TWDR_ADDR_PART_ID) || (addr == `TWDR_ADDR_REVISION);
    endfunction : twdr_is_local

endpackage : twdr_pkg

// ===== verilog/twdr_sync2.sv
`timescale 1ns/1ps
`default_nettype none

module twdr_sync2 (
    // Clock and reset
    input  wire logic clock,
    input  wire logic rst_n,
    // Level crossing
    input  wire logic async_level,
    output logic      sync_level
);

    logic first_stage;

    ////////////////////////////////////////////////////////////////////////////
    // Two flops, only the second is read outside
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            first_stage <= 1'b0;
            sync_level  <= 1'b0;
        end else begin
            first_stage <= async_level;
            sync_level  <= first_stage;
        end
    end

endmodule : twdr_sync2

`default_nettype wire

// ===== verilog/twdr_unlock.sv
`timescale 1ns/1ps
`default_nettype none

module twdr_unlock
    import twdr_pkg::*;
(
    // Clock, reset, enable
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       clock_enable,
    // Control register writes
    input  wire logic       write_strobe,
    input  wire logic [7:0] write_data,
    // Unlock state
    output logic            programming_enabled
);

    twdr_unlock_state_t state;
    twdr_unlock_state_t next_state;
    logic               next_programming_enabled;

    ////////////////////////////////////////////////////////////////////////////
    // Ordered code pair opens flash programming
    always_comb begin
        next_state = state;
        if (write_strobe) begin
            unique case (state)
                UL_LOCKED: begin
                    if (write_data == `TWDR_UNLOCK_FIRST) next_state = UL_HALF;
                end
                UL_HALF: begin
                    if (write_data == `TWDR_UNLOCK_SECOND) begin
                        next_state = UL_OPEN;
                    end else if (write_data == `TWDR_UNLOCK_FIRST) begin
                        next_state = UL_HALF;
                    end else begin
                        next_state = UL_LOCKED;
                    end
                end
                UL_OPEN: next_state = UL_OPEN;
                default: next_state = UL_LOCKED;
            endcase
        end
        next_programming_enabled = (next_state == UL_OPEN);
    end

    // Only a system reset leaves the open state
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state               <= UL_LOCKED;
            programming_enabled <= 1'b0;
        end else if (clock_enable) begin
            state               <= next_state;
            programming_enabled <= next_programming_enabled;
        end
    end

endmodule : twdr_unlock

`default_nettype wire

// ===== verilog/twdr_regs.sv
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Port gives flash programming and in-system debug
// - Two pins: shared data, incoming clock
// - 8-bit select steers data read/write
// - Decode id, revision, flash control, flash data
// - Decode the six checksum unit registers
// - Part id read returns fixed code
// - Revision read returns silicon revision code
// - Select register resets to zero
// - Flash enabled after codes 02 then 01
// - Enabled state held until system reset
// - Flash data carries commands, addresses, data
module twdr_regs
    import twdr_pkg::*;
#(
    parameter logic [7:0] PART_ID  = 8'h5a,  // Arbitrary value
    parameter logic [7:0] REVISION = 8'h0c   // Arbitrary value
) (
    // System clock, reset, enable
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       clock_enable,
    // Debug link pins
    input  wire logic       debug_clock_pin,
    input  wire logic       debug_data_in,
    output logic            debug_data_out,
    output logic            debug_data_oe,
    // Flash programming state, core must stay halted while set
    output logic            flash_programming_enabled,
    // Access port to flash controller and checksum unit
    output logic            core_req_valid,
    output logic            core_req_write,
    output logic [7:0]      core_req_addr,
    output logic [7:0]      core_req_wdata,
    input  wire logic       core_ack,
    input  wire logic [7:0] core_rdata
);

    ////////////////////////////////////////////////////////////////////////////
    // Link domain state
    twdr_link_state_t link_state;
    twdr_link_state_t next_link_state;
    logic [2:0]       link_cnt;
    logic [2:0]       next_link_cnt;
    logic [1:0]       link_ins;
    logic [1:0]       next_link_ins;
    logic [7:0]       link_wbuf;
    logic [7:0]       next_link_wbuf;
    logic [7:0]       link_shift;
    logic [7:0]       next_link_shift;
    logic [7:0]       select;
    logic [7:0]       next_select;
    logic             local_done;
    logic             next_local_done;
    logic             ack_seen;
    logic             next_ack_seen;
    logic             link_req_tog;
    logic             next_link_req_tog;
    logic             link_req_write;
    logic             next_link_req_write;
    logic [7:0]       link_req_addr;
    logic [7:0]       next_link_req_addr;
    logic [7:0]       link_req_wdata;
    logic [7:0]       next_link_req_wdata;
    logic             next_debug_data_out;
    logic             next_debug_data_oe;
    logic             link_ack_sync;

    // System domain state
    twdr_sys_state_t  sys_state;
    twdr_sys_state_t  next_sys_state;
    logic             req_seen;
    logic             next_req_seen;
    logic             sys_ack_tog;
    logic             next_sys_ack_tog;
    logic [7:0]       sys_rsp_data;
    logic [7:0]       next_sys_rsp_data;
    logic [7:0]       ctrl_value;
    logic [7:0]       next_ctrl_value;
    logic             next_core_req_valid;
    logic             next_core_req_write;
    logic [7:0]       next_core_req_addr;
    logic [7:0]       next_core_req_wdata;
    logic             sys_req_sync;
    logic             new_req;
    logic             unlock_write;

    // Access start decoded inside the link frame
    logic             start_access;
    logic             start_write;
    logic [7:0]       start_wdata;
    logic [7:0]       byte_in;

    ////////////////////////////////////////////////////////////////////////////
    // Link frame sequencer, sampled on the incoming clock
    always_comb begin
        next_link_state     = link_state;
        next_link_cnt       = link_cnt;
        next_link_ins       = link_ins;
        next_link_wbuf      = link_wbuf;
        next_link_shift     = link_shift;
        next_select         = select;
        next_local_done     = local_done;
        next_ack_seen       = ack_seen;
        next_link_req_tog   = link_req_tog;
        next_link_req_write = link_req_write;
        next_link_req_addr  = link_req_addr;
        next_link_req_wdata = link_req_wdata;
        next_debug_data_out = debug_data_out;
        next_debug_data_oe  = debug_data_oe;
        start_access        = 1'b0;
        start_write         = 1'b0;
        start_wdata         = `TWDR_REFUSED_DATA;
        byte_in             = {debug_data_in, link_wbuf[6:0]};
        unique case (link_state)
            LK_IDLE: begin
                if (debug_data_in) begin                       // Start bit
                    next_link_state = LK_INS;
                    next_link_cnt   = 3'h0;
                end
            end
            LK_INS: begin
                if (!link_cnt[0]) begin
                    next_link_ins[0] = debug_data_in;
                    next_link_cnt    = 3'h1;
                end else begin
                    next_link_ins = {debug_data_in, link_ins[0]};
                    next_link_cnt = 3'h0;
                    unique case ({debug_data_in, link_ins[0]})
                        `TWDR_INS_DATA_READ: begin
                            start_access = 1'b1;
                        end
                        `TWDR_INS_ADDR_READ: begin
                            next_link_shift     = select;
                            next_link_state     = LK_RDY;
                            next_debug_data_oe  = 1'b1;
                            next_debug_data_out = 1'b1;
                        end
                        default: next_link_state = LK_WDATA;
                    endcase
                end
            end
            LK_WDATA: begin
                next_link_wbuf[link_cnt] = debug_data_in;
                if (link_cnt == `TWDR_LAST_BIT) begin
                    next_link_cnt = 3'h0;
                    if (link_ins == `TWDR_INS_ADDR_WRITE) begin
                        next_select     = byte_in;
                        next_link_state = LK_IDLE;
                    end else begin
                        start_access = 1'b1;
                        start_write  = 1'b1;
                        start_wdata  = byte_in;
                    end
                end else begin
                    next_link_cnt = 3'(link_cnt + 3'h1);
                end
            end
            LK_WAIT: begin
                // Busy zeros until the access completes, then a ready one
                if (local_done || (link_ack_sync != ack_seen)) begin
                    next_ack_seen       = link_ack_sync;
                    next_local_done     = 1'b0;
                    next_debug_data_out = 1'b1;
                    next_link_state     = LK_RDY;
                    if (!local_done) next_link_shift = sys_rsp_data;
                end
            end
            LK_RDY: begin
                if (link_ins[0] == 1'b0) begin                 // Read kinds
                    next_link_state     = LK_RDATA;
                    next_link_cnt       = 3'h0;
                    next_debug_data_out = link_shift[0];
                end else begin
                    next_link_state     = LK_IDLE;
                    next_debug_data_oe  = 1'b0;
                    next_debug_data_out = 1'b0;
                end
            end
            LK_RDATA: begin
                if (link_cnt == `TWDR_LAST_BIT) begin
                    next_link_state     = LK_IDLE;
                    next_debug_data_oe  = 1'b0;
                    next_debug_data_out = 1'b0;
                end else begin
                    next_link_cnt       = 3'(link_cnt + 3'h1);
                    next_debug_data_out = link_shift[3'(link_cnt + 3'h1)];
                end
            end
            default: next_link_state = LK_IDLE;
        endcase

        // Identification registers answer at once, others cross over
        if (start_access) begin
            next_link_state     = LK_WAIT;
            next_debug_data_oe  = 1'b1;
            next_debug_data_out = 1'b0;
            if (twdr_is_local(select)) begin
                next_local_done = 1'b1;
                if (!start_write) begin
                    next_link_shift = (select == `TWDR_ADDR_PART_ID) ? PART_ID
                                                                      : REVISION;
                end
            end else begin
                next_link_req_write = start_write;
                next_link_req_addr  = select;
                next_link_req_wdata = start_wdata;
                next_link_req_tog   = ~link_req_tog;
            end
        end
    end

    // Link domain registers
    always_ff @(posedge debug_clock_pin or negedge rst_n) begin
        if (!rst_n) begin
            link_state     <= LK_IDLE;
            link_cnt       <= 3'h0;
            link_ins       <= 2'h0;
            link_wbuf      <= 8'h00;
            link_shift     <= 8'h00;
            select         <= `TWDR_SELECT_RESET;
            local_done     <= 1'b0;
            ack_seen       <= 1'b0;
            link_req_tog   <= 1'b0;
            link_req_write <= 1'b0;
            link_req_addr  <= 8'h00;
            link_req_wdata <= 8'h00;
            debug_data_out <= 1'b0;
            debug_data_oe  <= 1'b0;
        end else begin
            link_state     <= next_link_state;
            link_cnt       <= next_link_cnt;
            link_ins       <= next_link_ins;
            link_wbuf      <= next_link_wbuf;
            link_shift     <= next_link_shift;
            select         <= next_select;
            local_done     <= next_local_done;
            ack_seen       <= next_ack_seen;
            link_req_tog   <= next_link_req_tog;
            link_req_write <= next_link_req_write;
            link_req_addr  <= next_link_req_addr;
            link_req_wdata <= next_link_req_wdata;
            debug_data_out <= next_debug_data_out;
            debug_data_oe  <= next_debug_data_oe;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Toggle handshake crossings
    twdr_sync2 u_req_sync (
        .clock       (clock),
        .rst_n       (rst_n),
        .async_level (link_req_tog),
        .sync_level  (sys_req_sync)
    );

    twdr_sync2 u_ack_sync (
        .clock       (debug_clock_pin),
        .rst_n       (rst_n),
        .async_level (sys_ack_tog),
        .sync_level  (link_ack_sync)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Flash unlock sequence
    assign new_req      = (sys_state == SY_IDLE) && (sys_req_sync != req_seen);
    assign unlock_write = new_req && link_req_write
                       && (link_req_addr == `TWDR_ADDR_FLASH_CTRL);

    twdr_unlock u_unlock (
        .clock               (clock),
        .rst_n               (rst_n),
        .clock_enable        (clock_enable),
        .write_strobe        (unlock_write),
        .write_data          (link_req_wdata),
        .programming_enabled (flash_programming_enabled)
    );

    ////////////////////////////////////////////////////////////////////////////
    // System side decode and forwarding of crossed accesses
    always_comb begin
        next_sys_state      = sys_state;
        next_req_seen       = req_seen;
        next_sys_ack_tog    = sys_ack_tog;
        next_sys_rsp_data   = sys_rsp_data;
        next_ctrl_value     = ctrl_value;
        next_core_req_valid = 1'b0;
        next_core_req_write = core_req_write;
        next_core_req_addr  = core_req_addr;
        next_core_req_wdata = core_req_wdata;
        unique case (sys_state)
            SY_IDLE: begin
                if (new_req) begin
                    next_req_seen = sys_req_sync;
                    if (link_req_addr == `TWDR_ADDR_FLASH_CTRL) begin
                        if (link_req_write) next_ctrl_value = link_req_wdata;
                        else next_sys_rsp_data = ctrl_value;
                        next_sys_ack_tog = ~sys_ack_tog;
                    end else if (((link_req_addr == `TWDR_ADDR_FLASH_DATA)
                                  && flash_programming_enabled)
                                 || twdr_is_checksum(link_req_addr)) begin
                        next_core_req_valid = 1'b1;
                        next_core_req_write = link_req_write;
                        next_core_req_addr  = link_req_addr;
                        next_core_req_wdata = link_req_wdata;
                        next_sys_state      = SY_CORE;
                    end else begin
                        // Unmapped, or flash data while locked
                        next_sys_rsp_data = `TWDR_REFUSED_DATA;
                        next_sys_ack_tog  = ~sys_ack_tog;
                    end
                end
            end
            SY_CORE: begin
                if (core_ack) begin
                    if (!core_req_write) next_sys_rsp_data = core_rdata;
                    next_sys_ack_tog = ~sys_ack_tog;
                    next_sys_state   = SY_IDLE;
                end
            end
        endcase
    end

    // System domain registers, frozen while enable is low
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sys_state      <= SY_IDLE;
            req_seen       <= 1'b0;
            sys_ack_tog    <= 1'b0;
            sys_rsp_data   <= 8'h00;
            ctrl_value     <= `TWDR_CTRL_RESET;
            core_req_valid <= 1'b0;
            core_req_write <= 1'b0;
            core_req_addr  <= 8'h00;
            core_req_wdata <= 8'h00;
        end else if (clock_enable) begin
            sys_state      <= next_sys_state;
            req_seen       <= next_req_seen;
            sys_ack_tog    <= next_sys_ack_tog;
            sys_rsp_data   <= next_sys_rsp_data;
            ctrl_value     <= next_ctrl_value;
            core_req_valid <= next_core_req_valid;
            core_req_write <= next_core_req_write;
            core_req_addr  <= next_core_req_addr;
            core_req_wdata <= next_core_req_wdata;
        end
    end

endmodule : twdr_regs

`default_nettype wire

// ===== bench/twdr_properties.sv
`timescale 1ns/1ps
`default_nettype none

module twdr_properties (
    // Clocks and reset
    input wire logic       clock,
    input wire logic       rst_n,
    input wire logic       debug_clock_pin,
    // Link outputs
    input wire logic       debug_data_out,
    input wire logic       debug_data_oe,
    // Core side outputs
    input wire logic       flash_programming_enabled,
    input wire logic       core_req_valid,
    input wire logic       core_req_write,
    input wire logic [7:0] core_req_addr,
    input wire logic [7:0] core_req_wdata
);
    // Eight driven bits, then release
    sequence s_drive8;
        debug_data_oe [*8] ##1 !debug_data_oe;
    endsequence
    property p_addr_read;
        @(posedge debug_clock_pin) disable iff (!rst_n)
        $rose(debug_data_oe) && debug_data_out |=> s_drive8;
    endproperty
    property p_busy_ready;
        @(posedge debug_clock_pin) disable iff (!rst_n)
        $rose(debug_data_oe) && !debug_data_out |-> ##[1:300] debug_data_out;
    endproperty
    property p_req_map;
        @(posedge clock) disable iff (!rst_n) core_req_valid |->
        core_req_addr inside {8'hbf, 8'h91, 8'h94, 8'h95, 8'h96, 8'h97, 8'hd9};
    endproperty
    property p_locked;
        @(posedge clock) disable iff (!rst_n)
        core_req_valid && core_req_addr == 8'hbf |-> flash_programming_enabled;
    endproperty
    property p_open_hold;
        @(posedge clock) disable iff (!rst_n)
        flash_programming_enabled |=> flash_programming_enabled;
    endproperty
    property p_one_out;
        @(posedge clock) disable iff (!rst_n) core_req_valid |=> !core_req_valid [*8];
    endproperty
    property p_addr_hold;
        @(posedge clock) disable iff (!rst_n) !core_req_valid |-> $stable(core_req_addr);
    endproperty
    property p_data_hold;
        @(posedge clock) disable iff (!rst_n)
        !core_req_valid |-> $stable(core_req_wdata) && $stable(core_req_write);
    endproperty
    a_addr_read: assert property (p_addr_read) else $error("address read shape");
    a_busy_ready: assert property (p_busy_ready) else $error("no ready bit");
    a_req_map: assert property (p_req_map) else $error("core address");
    a_locked: assert property (p_locked) else $error("flash access locked");
    a_open_hold: assert property (p_open_hold) else $error("unlock lost");
    a_one_out: assert property (p_one_out) else $error("request too soon");
    a_addr_hold: assert property (p_addr_hold) else $error("address moved");
    a_data_hold: assert property (p_data_hold) else $error("data moved");
endmodule : twdr_properties

bind twdr_regs twdr_properties chk_u (.clock, .rst_n, .debug_clock_pin, .debug_data_out,
    .debug_data_oe, .flash_programming_enabled, .core_req_valid, .core_req_write,
    .core_req_addr, .core_req_wdata);

`default_nettype wire

// ===== bench/twdr_adapter.sv
`timescale 1ns/1ps
`default_nettype none

module twdr_adapter (
    // Link pins
    output logic      debug_clock_pin,
    output logic      debug_data_in,
    input  wire logic debug_data_out,
    input  wire logic debug_data_oe
);
    logic host_d = 1'b0;
    // Shared data wire, device wins while driving
    assign debug_data_in = debug_data_oe ? debug_data_out : host_d;
    initial begin
        debug_clock_pin = 1'b0;
    end
    // One link cycle; clock stands still between frames
    task automatic tick(input logic b, output logic o);
        host_d = b;
        #15;
        o = debug_data_oe & debug_data_out;
        debug_clock_pin = 1'b1;
        #15;
        debug_clock_pin = 1'b0;
    endtask : tick
    // Whole frame: start, code, data, wait for ready, read bits
    task automatic frame(input logic [1:0] ins, input logic [7:0] wd,
                         output logic [7:0] rd, output logic ok);
        logic o;
        int   n = 0;
        rd = 8'h00;
        tick(1'b1, o);
        tick(ins[0], o);
        tick(ins[1], o);
        if (ins[0]) for (int i = 0; i < 8; i++) tick(wd[i], o);
        if (ins != 2'h3) begin
            do begin
                tick(1'b0, o);
                n++;
            end while (o !== 1'b1 && n < 300);
            if (!ins[0]) for (int i = 0; i < 8; i++) begin
                tick(1'b0, o);
                rd[i] = o;
            end
        end
        host_d = 1'b0;
        ok = n < 300;
    endtask : frame
endmodule : twdr_adapter

`default_nettype wire

// ===== bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    localparam logic [7:0] PART_ID  = 8'ha7;  // Arbitrary value
    localparam logic [7:0] REVISION = 8'h3e;  // Arbitrary value
    logic       clock, rst_n, core_ack, ok, last_write;
    logic       debug_clock_pin, debug_data_in, debug_data_out, debug_data_oe;
    logic       flash_programming_enabled, core_req_valid, core_req_write;
    logic [7:0] core_rdata, core_req_addr, core_req_wdata, last_addr, last_wdata, rd;
    int         miscompares, cmp_count, req_n, lat;

    twdr_regs #(.PART_ID(PART_ID), .REVISION(REVISION)) dut_u (.clock, .rst_n,
        .clock_enable(1'b1), .debug_clock_pin, .debug_data_in, .debug_data_out,
        .debug_data_oe, .flash_programming_enabled, .core_req_valid, .core_req_write,
        .core_req_addr, .core_req_wdata, .core_ack, .core_rdata);
    twdr_adapter host_u (.debug_clock_pin, .debug_data_in, .debug_data_out, .debug_data_oe);

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    // Core stand-in: logs each request, answers after lat cycles
    initial begin
        core_ack = 1'b0;
        core_rdata = 8'h00;
        req_n = 0;
        forever begin
            @(posedge clock);
            if (core_req_valid === 1'b1) begin
                req_n++;
                {last_write, last_addr} = {core_req_write, core_req_addr};
                last_wdata = core_req_wdata;
                repeat (lat) @(posedge clock);
                core_ack <= 1'b1;
                core_rdata <= core_req_addr ^ 8'h5c;
                @(posedge clock);
                core_ack <= 1'b0;
                core_rdata <= ~core_rdata;
            end
        end
    end
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic acc(input logic [1:0] ins, input logic [7:0] wd);
        host_u.frame(ins, wd, rd, ok);
        chk("frame completion", 8'h01, {7'h00, ok});
    endtask : acc
    task automatic t_id;
        acc(2'h0, 8'h00);
        chk("part id after reset", PART_ID, rd);
        acc(2'h1, 8'hff);
        acc(2'h0, 8'h00);
        chk("part id after write", PART_ID, rd);
        acc(2'h3, 8'h01);
        acc(2'h2, 8'h00);
        chk("select readback", 8'h01, rd);
        acc(2'h1, 8'h00);
        acc(2'h0, 8'h00);
        chk("revision", REVISION, rd);
        chk("core requests", 8'h00, req_n[7:0]);
        $display("test id done");
    endtask : t_id
    task automatic t_csum;
        logic [7:0] a[6] = '{8'h96, 8'h97, 8'h91, 8'hd9, 8'h95, 8'h94};
        foreach (a[i]) begin
            lat = i * 7;
            acc(2'h3, a[i]);
            acc(2'h1, a[i] ^ 8'ha5);
            chk("csum address", a[i], last_addr);
            chk("csum wdata", a[i] ^ 8'ha5, last_wdata);
            chk("csum write kind", 8'h01, {7'h00, last_write});
            acc(2'h0, 8'h00);
            chk("csum rdata", a[i] ^ 8'h5c, rd);
            chk("csum read kind", 8'h00, {7'h00, last_write});
        end
        $display("test checksum done");
    endtask : t_csum
    task automatic t_flash;
        logic [7:0] c[4] = '{8'h06, 8'h07, 8'h08, 8'h03};
        logic [7:0] u[6] = '{8'h01, 8'h02, 8'h05, 8'h01, 8'h02, 8'h01};
        acc(2'h3, 8'hbf);
        acc(2'h0, 8'h00);
        chk("locked data", 8'h00, rd);
        acc(2'h1, 8'h06);
        chk("locked requests", 8'h0c, req_n[7:0]);
        acc(2'h3, 8'h02);
        foreach (u[i]) begin
            acc(2'h1, u[i]);
            #100;
            chk("unlock state", {7'h00, i == 5}, {7'h00, flash_programming_enabled});
        end
        acc(2'h0, 8'h00);
        chk("control readback", 8'h01, rd);
        acc(2'h3, 8'hbf);
        foreach (c[i]) begin
            acc(2'h1, c[i]);
            chk("flash command", c[i], last_wdata);
        end
        @(posedge clock);
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        #10;
        chk("unlock after reset", 8'h00, {7'h00, flash_programming_enabled});
        acc(2'h0, 8'h00);
        chk("select after reset", PART_ID, rd);
        $display("test flash done");
    endtask : t_flash
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : wrap_up
    // Main sequence
    initial begin
        rst_n <= 1'b0;
        lat = 1;
        miscompares = 0;
        cmp_count = 0;
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        t_id();
        t_csum();
        t_flash();
        wrap_up();
    end
    // Cut a hang short
    initial begin
        #300000;
        miscompares++;
        wrap_up();
    end
endmodule : tb_top

`default_nettype wire
